// ### logic/eeprom_slave.sv
// Two-wire serial memory slave with write guard and read flows
// Notes on behaviour
// - Guard high refuses every array write
// - Guard low or open has no effect
// - Guard sampled at fall before first data
// - Guarded first byte unacknowledged, write discarded
// - Array starts with every byte erased
// - Read direction reads at current address counter
// - Acknowledge address, then shift out byte
// - Master nacks then stops; slave idles
// - Counter loads fourteen received address bits
// - Master ack sends byte at next address
// - Sequential read wraps at end of memory
// - Respond only to 1010 plus strap match
// - Ignore top two bits; page and offset
// - Ack pulls line low; release for ones when sending
// - Busy write cycle: released line, requests ignored
`timescale 1ns/1ns
module eeprom_slave #(
  parameter int unsigned WRITE_CYCLE_CLKS = eeprom_pkg::WRITE_CYCLE_CLKS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic write_guard,
  input wire logic strap_select_bit0,
  input wire logic strap_select_bit1,
  input wire logic strap_select_bit2,
  output logic write_busy
);
  // Link domain synchronisers
  logic rst_m_q, rst_l_q;
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic wp_m_q, wp_s_q;
  logic [2:0] strap_m_q, strap_s_q;
  // Bus slave state
  eeprom_pkg::slave_state_t state_q, state_d;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic drive_q, mack_q, wp_lat_q, first_data_q, have_data_q;
  logic [5:0] hi_q;
  logic [eeprom_pkg::ADDR_W-1:0] addr_q;
  // Page buffer, array and write cycle hand-off
  logic [7:0] mem_q [2**eeprom_pkg::ADDR_W];
  logic [7:0] pg_mem_q [eeprom_pkg::PAGE_BYTES];
  logic [eeprom_pkg::PAGE_BYTES-1:0] pg_valid_q;
  logic busy_q, commit_pend_q, commit_run_q, req_tgl_q;
  logic [eeprom_pkg::OFS_W-1:0] commit_idx_q;
  logic done_m_q, done_s_q, done_p_q;
  // Reference domain write cycle timer
  logic req_m_q, req_s_q, req_p_q;
  logic [31:0] timer_q;
  logic busy_ref_q, done_tgl_q;

  byte_stream_if #(.WIDTH(eeprom_pkg::FIFO_W)) fifo_in ();
  byte_stream_if #(.WIDTH(eeprom_pkg::FIFO_W)) fifo_out ();

  stream_fifo #(
    .WIDTH(eeprom_pkg::FIFO_W),
    .DEPTH(eeprom_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(link_clk),
    .rst(rst_l_q),
    .push(fifo_in.snk),
    .pop(fifo_out.src)
  );

  // Erased delivery state of the array
  initial
  begin
    for (int i = 0; i < 2**eeprom_pkg::ADDR_W; i++)
      mem_q[i] = eeprom_pkg::ERASED_BYTE;
  end

  // Bring reset and pins into the link domain
  always_ff @(posedge link_clk)
  begin
    rst_m_q <= rst;
    rst_l_q <= rst_m_q;
    scl_m_q <= scl;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_i;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
    wp_m_q <= write_guard;
    wp_s_q <= wp_m_q;
    strap_m_q <= {strap_select_bit2, strap_select_bit1, strap_select_bit0};
    strap_s_q <= strap_m_q;
  end

  // Bus events and state decodes
  wire scl_rise = scl_s_q & ~scl_p_q;
  wire scl_fall = ~scl_s_q & scl_p_q;
  wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire at_byte_end = scl_fall & (bit_q == eeprom_pkg::BIT_LAST);
  wire at_ack_end = scl_fall & (bit_q == eeprom_pkg::BIT_ACK);
  wire in_dev = (state_q == eeprom_pkg::ST_DEV);
  wire in_hi = (state_q == eeprom_pkg::ST_ADR_HI);
  wire in_lo = (state_q == eeprom_pkg::ST_ADR_LO);
  wire in_wr = (state_q == eeprom_pkg::ST_WDATA);
  wire in_rd = (state_q == eeprom_pkg::ST_RDATA);
  wire type_ok = (shift_q[7:4] == eeprom_pkg::DEV_TYPE);
  wire addr_match = type_ok & (shift_q[3:1] == strap_s_q) & ~busy_q;
  wire rd_dir = shift_q[0];
  wire guard_reject = first_data_q & wp_lat_q;
  wire wr_ack = ~guard_reject & fifo_in.ready;
  wire ack_now = (in_dev & addr_match) | in_hi | in_lo | (in_wr & wr_ack);
  wire load_tx = at_ack_end & in_rd & mack_q;
  wire push_now = at_byte_end & in_wr & wr_ack;
  wire pop_now = fifo_out.valid & fifo_out.ready;
  wire [5:0] pop_ofs = fifo_out.data[13:8];
  wire [5:0] ofs_next = addr_q[5:0] + 6'h01;
  wire [7:0] mem_rd = mem_q[addr_q];
  wire commit_last = commit_run_q & (commit_idx_q == 6'h3f);
  wire done_edge = done_s_q ^ done_p_q;

  // Bytes go to the buffer with their page offset
  assign fifo_in.valid = push_now;
  assign fifo_in.data = {addr_q[5:0], shift_q};
  assign fifo_out.ready = ~commit_run_q;
  // Open drain pin: only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe = drive_q;

  // Next state
  always_comb
  begin
    state_d = state_q;
    if (bus_start)
      state_d = eeprom_pkg::ST_DEV;
    else if (bus_stop)
      state_d = eeprom_pkg::ST_IDLE;
    else if (at_byte_end)
    begin
      case (state_q)
        eeprom_pkg::ST_DEV:
          if (!addr_match)
            state_d = eeprom_pkg::ST_IGNORE;
          else if (rd_dir)
            state_d = eeprom_pkg::ST_RDATA;
          else
            state_d = eeprom_pkg::ST_ADR_HI;
        eeprom_pkg::ST_ADR_HI: state_d = eeprom_pkg::ST_ADR_LO;
        eeprom_pkg::ST_ADR_LO: state_d = eeprom_pkg::ST_WDATA;
        eeprom_pkg::ST_WDATA:
          if (!wr_ack)
            state_d = eeprom_pkg::ST_IGNORE;
        default: state_d = state_q;
      endcase
    end
    else if (at_ack_end & in_rd & ~mack_q)
      state_d = eeprom_pkg::ST_IGNORE;
  end

  // State and bit counter
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q)
    begin
      state_q <= eeprom_pkg::ST_IDLE;
      bit_q <= eeprom_pkg::BIT_FIRST;
    end
    else
    begin
      state_q <= state_d;
      // The clock fall after a start opens bit 7, so park in the ack slot
      if (bus_start)
        bit_q <= eeprom_pkg::BIT_ACK;
      else if (scl_fall)
        bit_q <= (bit_q == eeprom_pkg::BIT_ACK) ? eeprom_pkg::BIT_FIRST
                                                : bit_q + 4'h1;
    end
  end

  // Receive shift and master acknowledge sample on rising clock
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q)
    begin
      shift_q <= 8'h00;
      mack_q <= 1'b0;
    end
    else if (scl_rise & (bit_q == eeprom_pkg::BIT_ACK))
      mack_q <= ~sda_s_q;
    else if (scl_rise)
      shift_q <= {shift_q[6:0], sda_s_q};
  end

  // Line drive: ack slot or transmit bits, changed on falling clock
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q | bus_start | bus_stop)
      drive_q <= 1'b0;
    else if (at_byte_end)
      drive_q <= ack_now;
    else if (at_ack_end)
      drive_q <= load_tx & ~mem_rd[7];
    else if (scl_fall & in_rd)
      drive_q <= ~tx_q[6];
  end

  // Transmit byte register
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q)
      tx_q <= eeprom_pkg::ERASED_BYTE;
    else if (load_tx)
      tx_q <= mem_rd;
    else if (scl_fall & in_rd & (bit_q < eeprom_pkg::BIT_LAST))
      tx_q <= {tx_q[6:0], 1'b1};
  end

  // Address counter
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q)
    begin
      hi_q <= 6'h00;
      addr_q <= '0;
    end
    else if (at_byte_end & in_hi)
      hi_q <= shift_q[5:0];
    else if (at_byte_end & in_lo)
      addr_q <= {hi_q, shift_q};
    else if (load_tx)
      addr_q <= addr_q + 14'h0001;
    else if (push_now)
      addr_q <= {addr_q[13:6], ofs_next};
  end

  // Write guard capture and write request tracking
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q | bus_start)
    begin
      wp_lat_q <= 1'b0;
      first_data_q <= 1'b0;
    end
    else if (at_byte_end & in_lo)
      first_data_q <= 1'b1;
    else if (at_ack_end & in_wr & first_data_q)
      wp_lat_q <= wp_s_q;
    else if (at_byte_end & in_wr)
      first_data_q <= 1'b0;
  end

  // A guarded write never holds data, so no write cycle starts
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q | bus_start | bus_stop)
      have_data_q <= 1'b0;
    else if (at_byte_end & in_wr & guard_reject)
      have_data_q <= 1'b0;
    else if (push_now)
      have_data_q <= 1'b1;
  end

  // Page buffer valid flags: cleared per new sequence and after commit
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q | (at_byte_end & in_lo) | commit_last)
      pg_valid_q <= '0;
    else if (pop_now)
      pg_valid_q[pop_ofs] <= 1'b1;
  end

  // Page buffer contents, latest byte per offset wins
  always_ff @(posedge link_clk)
  begin
    if (pop_now)
      pg_mem_q[pop_ofs] <= fifo_out.data[7:0];
  end

  // Commit sequencing after the stop that ends a write
  always_ff @(posedge link_clk)
  begin
    if (rst_l_q)
    begin
      commit_pend_q <= 1'b0;
      commit_run_q <= 1'b0;
      commit_idx_q <= '0;
      req_tgl_q <= 1'b0;
    end
    else if (bus_stop & have_data_q)
      commit_pend_q <= 1'b1;
    else if (commit_pend_q & ~fifo_out.valid)
    begin
      commit_pend_q <= 1'b0;
      commit_run_q <= 1'b1;
      commit_idx_q <= '0;
    end
    else if (commit_last)
    begin
      commit_run_q <= 1'b0;
      req_tgl_q <= ~req_tgl_q;
    end
    else if (commit_run_q)
      commit_idx_q <= commit_idx_q + 6'h01;
  end

  // Array write from the page buffer; plain always as the erased fill
  // in the initial block also writes this array
  always @(posedge link_clk)
  begin
    if (commit_run_q & pg_valid_q[commit_idx_q])
      mem_q[{addr_q[13:6], commit_idx_q}] <= pg_mem_q[commit_idx_q];
  end

  // Busy from write stop until the timer reports done
  always_ff @(posedge link_clk)
  begin
    done_m_q <= done_tgl_q;
    done_s_q <= done_m_q;
    done_p_q <= done_s_q;
    if (rst_l_q)
      busy_q <= 1'b0;
    else if (bus_stop & have_data_q)
      busy_q <= 1'b1;
    else if (done_edge)
      busy_q <= 1'b0;
  end

  // Write cycle request crossing into the reference domain
  always_ff @(posedge ref_clk)
  begin
    req_m_q <= req_tgl_q;
    req_s_q <= req_m_q;
    req_p_q <= req_s_q;
  end

  // Write cycle timer
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      timer_q <= 32'h0;
      busy_ref_q <= 1'b0;
      done_tgl_q <= 1'b0;
    end
    else if (req_s_q ^ req_p_q)
    begin
      timer_q <= 32'(WRITE_CYCLE_CLKS - 1);
      busy_ref_q <= 1'b1;
    end
    else if (busy_ref_q & (timer_q == 32'h0))
    begin
      busy_ref_q <= 1'b0;
      done_tgl_q <= ~done_tgl_q;
    end
    else if (busy_ref_q)
      timer_q <= timer_q - 32'h1;
  end

  assign write_busy = busy_ref_q;
endmodule : eeprom_slave

// ### shared/eeprom_pkg.sv
// Constants and types shared by the serial memory slave design
package eeprom_pkg;
  // Slave address layout and memory geometry
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam int ADDR_W = 14;
  localparam int OFS_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Bit counter values within one nine-clock byte slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // Buffer between the byte receiver and the page buffer
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = OFS_W + 8;
  // Internal write cycle time and its length in reference clocks
  localparam int unsigned WRITE_CYCLE_US = 5000;
  localparam int unsigned REF_CLK_MHZ = 100;
  localparam int unsigned WRITE_CYCLE_CLKS = WRITE_CYCLE_US * REF_CLK_MHZ;
  // Bus slave states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEV = 7'h02,
    ST_ADR_HI = 7'h04,
    ST_ADR_LO = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_IGNORE = 7'h40
  } slave_state_t;
endpackage : eeprom_pkg

// ### shared/byte_stream_if.sv
// Valid and ready stream carrier between the slave and its buffer
`timescale 1ns/1ns
interface byte_stream_if #(parameter int WIDTH = 8) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// ### logic/stream_fifo.sv
// Single clock FIFO with valid and ready on both sides
`timescale 1ns/1ns
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  byte_stream_if.snk push,
  byte_stream_if.src pop
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store_q [DEPTH];
  logic [PW:0] wr_q;
  logic [PW:0] rd_q;

  // Pointers carry one extra wrap bit to tell full from empty
  wire full = (wr_q[PW] != rd_q[PW]) && (wr_q[PW-1:0] == rd_q[PW-1:0]);
  wire empty = (wr_q == rd_q);
  wire do_push = push.valid & ~full;
  wire do_pop = pop.ready & ~empty;

  assign push.ready = ~full;
  assign pop.valid = ~empty;
  assign pop.data = store_q[rd_q[PW-1:0]];

  // Pointer update
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + (PW+1)'(do_push);
      rd_q <= rd_q + (PW+1)'(do_pop);
    end
  end

  // Storage write
  always_ff @(posedge clk)
  begin
    if (do_push)
      store_q[wr_q[PW-1:0]] <= push.data;
  end
endmodule : stream_fifo

// ### bench/eeprom_slave_properties.sv
// Port checks for the serial memory slave
`timescale 1ns/1ns
module eeprom_slave_checker #(
  parameter int unsigned WRITE_CYCLE_CLKS = 50
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda_oe,
  input wire logic write_guard,
  input wire logic write_busy
);
  int unsigned busy_cnt_q;
  int unsigned oe_cnt_q;
  // Lengths of the current busy and drive stretches
  always_ff @(posedge ref_clk)
  begin
    busy_cnt_q <= write_busy ? busy_cnt_q + 1 : 0;
    oe_cnt_q <= sda_oe ? oe_cnt_q + 1 : 0;
  end
  a_reset_quiet: assert property (@(posedge ref_clk)
    rst [*8] |-> !sda_oe && !write_busy) else $error("active in reset");
  a_oe_rise_low: assert property (@(posedge link_clk) disable iff (rst)
    $rose(sda_oe) |-> !scl) else $error("drive began with clock high");
  a_oe_stable_high: assert property (@(posedge link_clk) disable iff (rst)
    scl && $past(scl) |-> $stable(sda_oe)) else $error("drive moved");
  a_oe_bounded: assert property (@(posedge ref_clk) disable iff (rst)
    oe_cnt_q < 200) else $error("data line held too long");
  a_busy_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
    write_busy |-> !sda_oe) else $error("drive during write cycle");
  a_busy_min: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(write_busy) |=> write_busy [*8]) else $error("busy too short");
  a_busy_length: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(write_busy) |-> busy_cnt_q == WRITE_CYCLE_CLKS)
    else $error("write cycle length wrong");
  a_guard_blocks: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(write_busy) |-> !write_guard) else $error("guarded write ran");
  // Main scenarios reached
  c_busy: cover property (@(posedge ref_clk) $rose(write_busy));
  c_drive: cover property (@(posedge link_clk) $rose(sda_oe));
  c_guard: cover property (@(posedge ref_clk) write_guard && !scl);
endmodule : eeprom_slave_checker
bind eeprom_slave eeprom_slave_checker #(
  .WRITE_CYCLE_CLKS(WRITE_CYCLE_CLKS)
) chk (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl(scl),
  .sda_oe(sda_oe), .write_guard(write_guard), .write_busy(write_busy));

// ### bench/i2c_master_model.sv
// Two-wire bus master that drives the slave under test
`timescale 1ns/1ns
module i2c_master_model (
  input wire logic ref_clk,
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // Bus idles released and high
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Start or repeated start, eight clocks a phase
  task automatic start();
    scl <= 1'b0;
    tick(4);
    sda_m <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_m <= 1'b0;
    tick(8);
  endtask : start
  task automatic stop();
    scl <= 1'b0;
    tick(4);
    sda_m <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_m <= 1'b1;
    tick(8);
  endtask : stop
  // One bit: data set while clock low, line read at end of high
  task automatic bit_x(input logic b, output logic r);
    scl <= 1'b0;
    tick(2);
    sda_m <= b;
    tick(6);
    scl <= 1'b1;
    tick(8);
    r = sda;
  endtask : bit_x
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic ackb, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(!ackb, r);
  endtask : rd_byte
endmodule : i2c_master_model

// ### bench/serial_eeprom_read_and_write_guard_tb.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", nm, exp, got); end end
module serial_eeprom_read_and_write_guard_tb;
  localparam int unsigned WRITE_CYCLE_CLKS = 400;
  localparam logic [6:0] DEV = 7'h55;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic write_guard = 1'b0;
  logic [2:0] strap = 3'h5;
  logic scl, sda_m, sda_oe, write_busy;
  wire sda;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // Open-drain line with pull-up
  assign sda = sda_m & ~sda_oe;
  initial forever #5 ref_clk = ~ref_clk;
  initial
  begin
    #1;
    forever #3 link_clk = ~link_clk;
  end
  eeprom_slave #(.WRITE_CYCLE_CLKS(WRITE_CYCLE_CLKS)) uut (
    .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .scl(scl),
    .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .write_guard(write_guard),
    .strap_select_bit0(strap[0]), .strap_select_bit1(strap[1]),
    .strap_select_bit2(strap[2]), .write_busy(write_busy));
  i2c_master_model m (.ref_clk(ref_clk), .scl(scl), .sda_m(sda_m),
    .sda(sda));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  task automatic addr_phase(input logic [7:0] hi, input logic [7:0] lo);
    logic a;
    m.start();
    m.wr_byte({DEV, 1'b0}, a);
    `CHK("dev_ack", 1'b1, a)
    m.wr_byte(hi, a);
    `CHK("hi_ack", 1'b1, a)
    m.wr_byte(lo, a);
    `CHK("lo_ack", 1'b1, a)
  endtask : addr_phase
  // Wrong type code or strap levels get no acknowledge
  task automatic t_strap();
    logic a;
    m.start();
    m.wr_byte({7'h53, 1'b0}, a);
    `CHK("strap_nack", 1'b0, a)
    m.start();
    m.wr_byte({7'h75, 1'b0}, a);
    `CHK("type_nack", 1'b0, a)
    m.stop();
  endtask : t_strap
  // Byte write, guarded or not, then one address attempt (nacked after an unguarded write, acked after a guarded one) and a wait for busy end
  task automatic t_write(input logic [7:0] hi, input logic [7:0] lo,
    input logic [7:0] d, input logic g);
    logic a;
    int n;
    write_guard <= g;
    addr_phase(hi, lo);
    m.wr_byte(d, a);
    `CHK("data_ack", !g, a)
    m.stop();
    n = 0;
    while (write_busy !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("busy_start", !g, write_busy)
    m.start();
    m.wr_byte({DEV, 1'b0}, a);
    `CHK("next_ack", g, a)
    m.stop();
    n = 0;
    while (write_busy === 1'b1 && n < 600)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("busy_end", 1'b0, write_busy)
    write_guard <= 1'b0;
  endtask : t_write
  // Random read of two bytes with dummy write and restart
  task automatic t_read(input logic [7:0] hi, input logic [7:0] lo,
    input logic [7:0] e0, input logic [7:0] e1);
    logic a;
    logic [7:0] d;
    addr_phase(hi, lo);
    m.start();
    m.wr_byte({DEV, 1'b1}, a);
    `CHK("rd_ack", 1'b1, a)
    m.rd_byte(1'b1, d);
    `CHK("rd_first", e0, d)
    m.rd_byte(1'b0, d);
    `CHK("rd_next", e1, d)
    m.stop();
  endtask : t_read
  // Read at the current counter value
  task automatic t_cur(input logic [7:0] e);
    logic a;
    logic [7:0] d;
    m.start();
    m.wr_byte({DEV, 1'b1}, a);
    `CHK("cur_ack", 1'b1, a)
    m.rd_byte(1'b0, d);
    `CHK("cur_data", e, d)
    m.stop();
  endtask : t_cur
  // Cycle ceiling against a hang
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    t_strap();
    t_write(8'h3f, 8'hff, 8'h5a, 1'b0);
    t_write(8'hc0, 8'h00, 8'ha5, 1'b0);
    t_write(8'h00, 8'h01, 8'h96, 1'b0);
    t_write(8'h00, 8'h40, 8'h3c, 1'b1);
    t_read(8'h3f, 8'hff, 8'h5a, 8'ha5);
    t_cur(8'h96);
    t_read(8'h00, 8'h40, 8'hff, 8'hff);
    print_verdict();
  end
endmodule : serial_eeprom_read_and_write_guard_tb
